// file: logic/irq2_status_bank.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// - shared memory collision rise sets bit 15
// - control port error rise sets bit 12
// - clock failure bit 9, boot bit 7, rising
// - lock loop flags set on either edge
// - accessory flag set by detection event pulse
// - headphone detect done rise sets bit 0
// - clamp rise bit 4, clamp fall bit 5
// - jack two rise bit 2, fall bit 3
// - jack one rise bit 0, fall bit 1
// - rate converter lock flags on either edge
// - range unit detect flags on either edge
// - processor line n sets bit n-1, rising
// - writing one clears; zero leaves flag alone
module irq2_status_bank #(
  parameter int ADDR_W = irq2_bank_pkg::MIN_ADDR_W
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  // sources
  input wire logic shared_mem_collision, // shared memory write collision level
  input wire logic control_port_error, // control interface error level
  input wire logic system_clock_failure, // system clock fail level
  input wire logic boot_complete, // boot done level
  input wire logic [2:0] lock_loop_lock, // lock loop 3..1 lock levels
  input wire logic accessory_detect_event, // one-cycle detection event pulse
  input wire logic headphone_detect_done, // headphone detection done level
  input wire logic clamp_level, // mic accessory detect clamp level
  input wire logic jack_detect_one, // first jack detect level
  input wire logic jack_detect_two, // second jack detect level
  input wire logic [3:0] rate_conv_lock, // c2in2, c2in1, c1in2, c1in1 lock
  input wire logic [1:0] range_unit_signal, // dynamic range units 2, 1 detect
  input wire logic [13:0] processor_lines, // bit k is processor line k+3
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);

  // ==========================================================================
  // parameter check
  // ==========================================================================
  if (ADDR_W < irq2_bank_pkg::MIN_ADDR_W || ADDR_W > irq2_bank_pkg::DATA_W) begin : g_bad_a
    $error("irq2_status_bank needs ADDR_W between 18 and 32");
  end

  localparam int NR = irq2_bank_pkg::REG_COUNT;
  localparam int FW = irq2_bank_pkg::FLAG_W;

  typedef struct packed {
    logic hit;
    logic [irq2_bank_pkg::SLOT_W-1:0] slot;
  } decode_t;

  typedef struct packed {
    irq2_bank_pkg::wr_state_e wst;
    irq2_bank_pkg::rd_state_e rst;
    logic aw_got;
    logic [ADDR_W-1:0] waddr;
    logic w_got;
    logic [FW-1:0] wdata_lo;
    logic [1:0] wstrb_lo;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NR-1:0][FW-1:0] flags;
  } bank_state_s;

  bank_state_s state_ff;
  bank_state_s nxt_state;

  // ==========================================================================
  // address decode
  // ==========================================================================
  // byte offsets within a word are ignored; the bus moves whole words
  function automatic decode_t decode_addr(input logic [ADDR_W-1:0] addr);
    decode_t res;
    res = '0;
    for (int i = 0; i < NR; i++) begin
      // bits above the index must be zero as well, or the access misses
      if ((addr >> irq2_bank_pkg::WORD_LSB) == ADDR_W'(irq2_bank_pkg::REG_INDEX[i])) begin
        res.hit = 1'b1;
        res.slot = irq2_bank_pkg::SLOT_W'(i);
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // source edges
  // ==========================================================================
  logic [irq2_bank_pkg::LVL_W-1:0] src_lvl;

  assign src_lvl = {processor_lines, range_unit_signal, rate_conv_lock, jack_detect_two,
                    jack_detect_one, clamp_level, headphone_detect_done, lock_loop_lock,
                    boot_complete, system_clock_failure, control_port_error,
                    shared_mem_collision};

  edge_if #(.W(irq2_bank_pkg::LVL_W)) src_edges ();

  source_edge_detect #(.W(irq2_bank_pkg::LVL_W)) u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(src_lvl),
    .edges(src_edges.src)
  );

  logic [irq2_bank_pkg::LVL_W-1:0] rise;
  logic [irq2_bank_pkg::LVL_W-1:0] fall;
  logic [NR-1:0][FW-1:0] set_vec;

  assign rise = src_edges.rise;
  assign fall = src_edges.fall;

  always_comb begin
    set_vec = '0;
    set_vec[irq2_bank_pkg::SLOT_SYSTEM][irq2_bank_pkg::BIT_SHARED_MEM_COLLISION] =
      rise[irq2_bank_pkg::LV_COLLISION];
    set_vec[irq2_bank_pkg::SLOT_SYSTEM][irq2_bank_pkg::BIT_CONTROL_PORT_ERROR] =
      rise[irq2_bank_pkg::LV_CTRL_ERROR];
    set_vec[irq2_bank_pkg::SLOT_SYSTEM][irq2_bank_pkg::BIT_SYSTEM_CLOCK_FAILURE] =
      rise[irq2_bank_pkg::LV_CLOCK_FAIL];
    set_vec[irq2_bank_pkg::SLOT_SYSTEM][irq2_bank_pkg::BIT_BOOT_COMPLETE] =
      rise[irq2_bank_pkg::LV_BOOT];

    for (int i = 0; i < irq2_bank_pkg::LOCK_LOOP_COUNT; i++) begin
      set_vec[irq2_bank_pkg::SLOT_LOCK][irq2_bank_pkg::BIT_LOCK_LOOP1 + i] =
        rise[irq2_bank_pkg::LV_LOCK + i] | fall[irq2_bank_pkg::LV_LOCK + i];
    end
    // the detection logic already qualifies its event, so no edge is taken
    set_vec[irq2_bank_pkg::SLOT_ACCESSORY][irq2_bank_pkg::BIT_ACCESSORY_DETECT] =
      accessory_detect_event;
    set_vec[irq2_bank_pkg::SLOT_ACCESSORY][irq2_bank_pkg::BIT_HEADPHONE_DETECT] =
      rise[irq2_bank_pkg::LV_HEADPHONE];

    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_CLAMP_RISE] =
      rise[irq2_bank_pkg::LV_CLAMP];
    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_CLAMP_FALL] =
      fall[irq2_bank_pkg::LV_CLAMP];
    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_JACK2_RISE] =
      rise[irq2_bank_pkg::LV_JACK2];
    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_JACK2_FALL] =
      fall[irq2_bank_pkg::LV_JACK2];
    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_JACK1_RISE] =
      rise[irq2_bank_pkg::LV_JACK1];
    set_vec[irq2_bank_pkg::SLOT_JACK][irq2_bank_pkg::BIT_JACK1_FALL] =
      fall[irq2_bank_pkg::LV_JACK1];
    for (int i = 0; i < irq2_bank_pkg::RATE_CONV_COUNT; i++) begin
      set_vec[irq2_bank_pkg::SLOT_RATE][irq2_bank_pkg::BIT_RATE_CONV1_IN1 + i] =
        rise[irq2_bank_pkg::LV_RATE + i] | fall[irq2_bank_pkg::LV_RATE + i];
    end
    for (int i = 0; i < irq2_bank_pkg::RANGE_UNIT_COUNT; i++) begin
      set_vec[irq2_bank_pkg::SLOT_RATE][irq2_bank_pkg::BIT_RANGE_UNIT1 + i] =
        rise[irq2_bank_pkg::LV_RANGE + i] | fall[irq2_bank_pkg::LV_RANGE + i];
    end
    for (int i = 0; i < irq2_bank_pkg::PROC_LINE_COUNT; i++) begin
      set_vec[irq2_bank_pkg::SLOT_PROC][irq2_bank_pkg::BIT_PROCESSOR_LINE3 + i] =
        rise[irq2_bank_pkg::LV_PROC + i];
    end
  end

  // ==========================================================================
  // bus and flag state
  // ==========================================================================
  logic aw_hs;
  logic w_hs;
  logic [NR-1:0][FW-1:0] clr_vec;
  decode_t wdec;
  decode_t rdec;
  logic [FW-1:0] lane_mask;

  assign aw_hs = awvalid & state_ff.awready;
  assign w_hs = wvalid & state_ff.wready;

  always_comb begin
    nxt_state = state_ff;
    clr_vec = '0;
    wdec = '0;
    rdec = '0;
    lane_mask = '0;

    // write channel: address and data accepted in either order
    case (state_ff.wst)
      irq2_bank_pkg::W_IDLE: begin
        // an early half waits latched until the other half is taken
        if (aw_hs) begin
          nxt_state.aw_got = 1'b1;
          nxt_state.waddr = awaddr;
        end
        if (w_hs) begin
          nxt_state.w_got = 1'b1;
          nxt_state.wdata_lo = wdata[FW-1:0];
          nxt_state.wstrb_lo = wstrb[1:0];
        end
        if (nxt_state.aw_got && nxt_state.w_got) begin
          wdec = decode_addr(nxt_state.waddr);
          lane_mask = {{8{nxt_state.wstrb_lo[1]}}, {8{nxt_state.wstrb_lo[0]}}};
          if (wdec.hit) begin
            clr_vec[wdec.slot] = nxt_state.wdata_lo & lane_mask;
          end
          nxt_state.bresp = wdec.hit ? irq2_bank_pkg::RESP_OKAY : irq2_bank_pkg::RESP_SLVERR;
          nxt_state.bvalid = 1'b1;
          nxt_state.wst = irq2_bank_pkg::W_RESP;
        end
      end
      irq2_bank_pkg::W_RESP: begin
        if (bready) begin
          nxt_state.bvalid = 1'b0;
          nxt_state.aw_got = 1'b0;
          nxt_state.w_got = 1'b0;
          nxt_state.wst = irq2_bank_pkg::W_IDLE;
        end
      end
      default: begin
        nxt_state.wst = irq2_bank_pkg::W_IDLE;
      end
    endcase
    nxt_state.awready = nxt_state.wst == irq2_bank_pkg::W_IDLE && !nxt_state.aw_got;
    nxt_state.wready = nxt_state.wst == irq2_bank_pkg::W_IDLE && !nxt_state.w_got;

    // read channel: reads have no side effect on the flags
    case (state_ff.rst)
      irq2_bank_pkg::R_IDLE: begin
        // the word returned is the flags as registered before this edge
        if (arvalid && state_ff.arready) begin
          rdec = decode_addr(araddr);
          nxt_state.rdata = '0;
          if (rdec.hit) begin
            nxt_state.rdata[FW-1:0] = state_ff.flags[rdec.slot];
          end
          nxt_state.rresp = rdec.hit ? irq2_bank_pkg::RESP_OKAY : irq2_bank_pkg::RESP_SLVERR;
          nxt_state.rvalid = 1'b1;
          nxt_state.rst = irq2_bank_pkg::R_DATA;
        end
      end
      irq2_bank_pkg::R_DATA: begin
        if (rready) begin
          nxt_state.rvalid = 1'b0;
          nxt_state.rst = irq2_bank_pkg::R_IDLE;
        end
      end
      default: begin
        nxt_state.rst = irq2_bank_pkg::R_IDLE;
      end
    endcase
    nxt_state.arready = nxt_state.rst == irq2_bank_pkg::R_IDLE;

    // sticky flags; a set in the clearing cycle survives the clear
    for (int i = 0; i < NR; i++) begin
      nxt_state.flags[i] = ((state_ff.flags[i] & ~clr_vec[i]) | set_vec[i]) &
                           irq2_bank_pkg::REG_MASK[i];
    end
  end

  // reset leaves both channels idle and every flag clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
      state_ff.wst <= irq2_bank_pkg::W_IDLE;
      state_ff.rst <= irq2_bank_pkg::R_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // every output is a state field, so each leaves straight from a flop
  assign awready = state_ff.awready;
  assign wready = state_ff.wready;
  assign bvalid = state_ff.bvalid;
  assign bresp = state_ff.bresp;
  assign arready = state_ff.arready;
  assign rvalid = state_ff.rvalid;
  assign rdata = state_ff.rdata;
  assign rresp = state_ff.rresp;

endmodule

// file: logic/irq2_bank_pkg.sv
package irq2_bank_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  // printed offsets are register indexes; byte address is four times the index
  localparam int REG_COUNT = 6;
  localparam int FLAG_W = 16;
  localparam int DATA_W = 32;
  localparam int MIN_ADDR_W = 18;
  localparam int WORD_LSB = 2;
  localparam int SLOT_W = 3;

  localparam logic [15:0] IDX_SYSTEM_EVENT = 16'h1900;
  localparam logic [15:0] IDX_LOCK_LOOP_EVENT = 16'h1901;
  localparam logic [15:0] IDX_ACCESSORY_DETECT = 16'h1905;
  localparam logic [15:0] IDX_JACK_CLAMP_EDGE = 16'h1906;
  localparam logic [15:0] IDX_RATE_CONV_LEVEL = 16'h1908;
  localparam logic [15:0] IDX_PROCESSOR_LINE = 16'h190a;

  // storage slots, in the order of the index table below
  localparam logic [SLOT_W-1:0] SLOT_SYSTEM = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_LOCK = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_ACCESSORY = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_JACK = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_RATE = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_PROC = 3'h5;

  localparam logic [REG_COUNT-1:0][15:0] REG_INDEX = {
    IDX_PROCESSOR_LINE, IDX_RATE_CONV_LEVEL, IDX_JACK_CLAMP_EDGE,
    IDX_ACCESSORY_DETECT, IDX_LOCK_LOOP_EVENT, IDX_SYSTEM_EVENT};

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int BIT_SHARED_MEM_COLLISION = 15;
  localparam int BIT_CONTROL_PORT_ERROR = 12;
  localparam int BIT_SYSTEM_CLOCK_FAILURE = 9;
  localparam int BIT_BOOT_COMPLETE = 7;
  localparam int BIT_LOCK_LOOP1 = 8;
  localparam int LOCK_LOOP_COUNT = 3;
  localparam int BIT_ACCESSORY_DETECT = 8;
  localparam int BIT_HEADPHONE_DETECT = 0;
  localparam int BIT_JACK1_RISE = 0;
  localparam int BIT_JACK1_FALL = 1;
  localparam int BIT_JACK2_RISE = 2;
  localparam int BIT_JACK2_FALL = 3;
  localparam int BIT_CLAMP_RISE = 4;
  localparam int BIT_CLAMP_FALL = 5;
  localparam int BIT_RATE_CONV1_IN1 = 8;
  localparam int RATE_CONV_COUNT = 4;
  localparam int BIT_RANGE_UNIT1 = 0;
  localparam int RANGE_UNIT_COUNT = 2;
  localparam int BIT_PROCESSOR_LINE3 = 2;
  localparam int PROC_LINE_COUNT = 14;

  localparam logic [15:0] ONE_BIT = 16'h0001;
  localparam logic [REG_COUNT-1:0][15:0] REG_MASK = {
    16'hffff << BIT_PROCESSOR_LINE3,
    (16'h000f << BIT_RATE_CONV1_IN1) | (16'h0003 << BIT_RANGE_UNIT1),
    16'h003f << BIT_JACK1_RISE,
    (ONE_BIT << BIT_ACCESSORY_DETECT) | (ONE_BIT << BIT_HEADPHONE_DETECT),
    16'h0007 << BIT_LOCK_LOOP1,
    (ONE_BIT << BIT_SHARED_MEM_COLLISION) | (ONE_BIT << BIT_CONTROL_PORT_ERROR) |
      (ONE_BIT << BIT_SYSTEM_CLOCK_FAILURE) | (ONE_BIT << BIT_BOOT_COMPLETE)};

  // ==========================================================================
  // positions in the packed source level vector
  // ==========================================================================
  localparam int LV_COLLISION = 0;
  localparam int LV_CTRL_ERROR = 1;
  localparam int LV_CLOCK_FAIL = 2;
  localparam int LV_BOOT = 3;
  localparam int LV_LOCK = 4;
  localparam int LV_HEADPHONE = 7;
  localparam int LV_CLAMP = 8;
  localparam int LV_JACK1 = 9;
  localparam int LV_JACK2 = 10;
  localparam int LV_RATE = 11;
  localparam int LV_RANGE = 15;
  localparam int LV_PROC = 17;
  localparam int LVL_W = 31;

  // ==========================================================================
  // bus codes and machine states
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_e;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_e;

endpackage

// file: logic/edge_if.sv
`timescale 1ns/10ps
interface edge_if #(parameter int W = 1);
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// file: logic/source_edge_detect.sv
`timescale 1ns/10ps
module source_edge_detect #(
  parameter int W = 1
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [W-1:0] level, // source levels
  edge_if.src edges // rise and fall pulses
);

  // ==========================================================================
  // parameter check
  // ==========================================================================
  if (W < 1) begin : g_bad_w
    $error("source_edge_detect needs W of at least one");
  end

  typedef struct packed {
    logic primed;
    logic [W-1:0] prev;
  } det_state_s;

  det_state_s state_ff;
  det_state_s nxt_state;

  // ==========================================================================
  // state
  // ==========================================================================
  // the first cycle after reset only captures the levels: a source already
  // high at reset is not reported as a rise
  always_comb begin
    nxt_state = state_ff;
    nxt_state.primed = 1'b1;
    nxt_state.prev = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign edges.rise = {W{state_ff.primed}} & level & ~state_ff.prev;
  assign edges.fall = {W{state_ff.primed}} & ~level & state_ff.prev;

endmodule

// file: verification/irq2_status_bank_checker.sv
`timescale 1ns/10ps
module irq2_status_bank_checker #(
  parameter int ADDR_W = 18
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  input wire logic rready // read data ready
);
  // ==========================================================================
  // decode of the address taken, held while its answer stands
  // ==========================================================================
  logic rd_hit_ff;
  logic wr_hit_ff;
  logic [15:0] rd_mask_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_hit_ff <= 1'b0;
      wr_hit_ff <= 1'b0;
      rd_mask_ff <= 16'h0000;
    end else begin
      for (int i = 0; i < irq2_bank_pkg::REG_COUNT; i++) begin
        if (arvalid && arready) begin
          if ((araddr >> 2) == ADDR_W'(irq2_bank_pkg::REG_INDEX[i])) begin
            rd_hit_ff <= 1'b1;
            rd_mask_ff <= irq2_bank_pkg::REG_MASK[i];
          end else if (i == 0) begin
            rd_hit_ff <= 1'b0;
          end
        end
        if (awvalid && awready) begin
          if ((awaddr >> 2) == ADDR_W'(irq2_bank_pkg::REG_INDEX[i])) begin
            wr_hit_ff <= 1'b1;
          end else if (i == 0) begin
            wr_hit_ff <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_ready_low_resp: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_ready_returns: assert property (bvalid && bready |=>
    !bvalid ##[0:1] (awready && wready))
    else $error("write channel not reopened");
  a_write_refused: assert property (bvalid |-> bresp == (wr_hit_ff ? 2'h0 : 2'h2))
    else $error("write response code wrong");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  a_rdata_stands: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before taken");
  a_upper_half_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  a_unmapped_read: assert property (rvalid && !rd_hit_ff |->
    rresp == 2'h2 && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_unused_bits_zero: assert property (rvalid && rd_hit_ff |->
    rresp == 2'h0 && (rdata[15:0] & ~rd_mask_ff) == 16'h0000)
    else $error("unused flag bit reads one");

  c_unmapped_read: cover property (rvalid && !rd_hit_ff);
  c_slow_bready: cover property (bvalid && !bready ##1 bvalid && bready);
  c_flag_read: cover property (rvalid && rd_hit_ff && rdata != 32'h0000_0000);
endmodule

bind irq2_status_bank irq2_status_bank_checker #(.ADDR_W(ADDR_W)) u_checker (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready));

// file: verification/tb_irq2_status_bank.sv
`timescale 1ns/10ps
module tb_irq2_status_bank;
  logic aclk, aresetn, shared_mem_collision, control_port_error, system_clock_failure;
  logic boot_complete, accessory_detect_event, headphone_detect_done, clamp_level;
  logic jack_detect_one, jack_detect_two;
  logic [2:0] lock_loop_lock;
  logic [3:0] rate_conv_lock;
  logic [1:0] range_unit_signal;
  logic [13:0] processor_lines;
  logic [17:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares, n_checks;
  logic [31:0] rise_exp [6] = '{32'h0000_9280, 32'h0000_0700, 32'h0000_0101,
    32'h0000_0015, 32'h0000_0f03, 32'h0000_fffc};
  logic [31:0] fall_exp [6] = '{32'h0000_0000, 32'h0000_0700, 32'h0000_0000,
    32'h0000_002a, 32'h0000_0f03, 32'h0000_0000};

  irq2_status_bank #(.ADDR_W(18)) dut (
    .aclk(aclk), .aresetn(aresetn), .shared_mem_collision(shared_mem_collision),
    .control_port_error(control_port_error), .system_clock_failure(system_clock_failure),
    .boot_complete(boot_complete), .lock_loop_lock(lock_loop_lock),
    .accessory_detect_event(accessory_detect_event),
    .headphone_detect_done(headphone_detect_done), .clamp_level(clamp_level),
    .jack_detect_one(jack_detect_one), .jack_detect_two(jack_detect_two),
    .rate_conv_lock(rate_conv_lock), .range_unit_signal(range_unit_signal),
    .processor_lines(processor_lines), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    miscompares++;
    $display("[FAIL] %0t bus answer never came", $time);
    complete_run();
  endtask

  function automatic logic [17:0] addr_of(input int i);
    return {irq2_bank_pkg::REG_INDEX[i], 2'b00};
  endfunction

  // every bus task starts just after a clock edge and returns just after one
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er,
                    input int stall);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (n + 1 >= stall) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 40) hang();
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input int stall);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (n + 1 >= stall) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 40) hang();
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic set_src(input logic v);
    shared_mem_collision <= v;
    control_port_error <= v;
    system_clock_failure <= v;
    boot_complete <= v;
    lock_loop_lock <= {3{v}};
    headphone_detect_done <= v;
    clamp_level <= v;
    jack_detect_one <= v;
    jack_detect_two <= v;
    rate_conv_lock <= {4{v}};
    range_unit_signal <= {2{v}};
    processor_lines <= {14{v}};
    repeat (2) @(posedge aclk);
  endtask

  task automatic clear_all;
    for (int i = 0; i < 6; i++) wr(addr_of(i), 32'h0000_ffff, 2'h0, 0);
  endtask

  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    aresetn = 1'b0;
    {shared_mem_collision, control_port_error, system_clock_failure, boot_complete} = 4'h0;
    {accessory_detect_event, headphone_detect_done, clamp_level} = 3'h0;
    {jack_detect_one, jack_detect_two} = 2'h0;
    {lock_loop_lock, rate_conv_lock, range_unit_signal, processor_lines} = 23'h00_0000;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    miscompares = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wstrb <= 4'hf;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rd(addr_of(i), 32'h0000_0000, 2'h0, i % 3);
    rd(18'h0_6408, 32'h0000_0000, 2'h2, 0);
    wr(18'h0_640c, 32'hffff_ffff, 2'h2, 3);
    // accessory input is a one-cycle event; its flag must outlive the pulse
    accessory_detect_event <= 1'b1;
    @(posedge aclk);
    accessory_detect_event <= 1'b0;
    set_src(1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(addr_of(i), rise_exp[i], 2'h0, 0);
    end
    for (int i = 3; i < 6; i++) begin
      rd(addr_of(i), rise_exp[i], 2'h0, 0);
    end
    wr(addr_of(0), 32'h0001_8000, 2'h0, 0);
    rd(addr_of(0), 32'h0000_1280, 2'h0, 0);
    clear_all();
    for (int i = 0; i < 6; i++) rd(addr_of(i), 32'h0000_0000, 2'h0, 0);
    set_src(1'b0);
    for (int i = 0; i < 6; i++) begin
      rd(addr_of(i), fall_exp[i], 2'h0, 0);
    end
    clear_all();
    processor_lines <= 14'h0001;
    lock_loop_lock <= 3'h4;
    repeat (2) @(posedge aclk);
    rd(addr_of(5), 32'h0000_0004, 2'h0, 0);
    rd(addr_of(1), 32'h0000_0400, 2'h0, 0);
    wstrb <= 4'h2;
    wr(addr_of(5), 32'h0000_ffff, 2'h0, 0);
    wstrb <= 4'hf;
    rd(addr_of(5), 32'h0000_0004, 2'h0, 0);
    // set and clear land on the same edge
    shared_mem_collision <= 1'b1;
    wr(addr_of(0), 32'h0000_8000, 2'h0, 0);
    rd(addr_of(0), 32'h0000_8000, 2'h0, 0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(addr_of(0), 32'h0000_0000, 2'h0, 0);
    rd(addr_of(5), 32'h0000_0000, 2'h0, 0);
    complete_run();
  end
endmodule
